// File: logic/ssr_map.svh
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// register select codes in the low three bits of a loaded word
`define SSR_SEL_INT_NUMERATOR_VALUE    3'h0
`define SSR_SEL_MOD_PHASE   3'h1
`define SSR_SEL_REF_CP      3'h2
`define SSR_SEL_CLK_DIV     3'h3
`define SSR_SEL_OUT_BAND    3'h4
`define SSR_SEL_LOCK_PIN    3'h5

// field positions
`define SSR_INT_MSB         30
`define SSR_INT_LSB         15
`define SSR_NUMERATOR_VALUE_MSB        14
`define SSR_NUMERATOR_VALUE_LSB        3
`define SSR_PRESCALER_BIT   27
`define SSR_DBUF_EN_BIT     13
`define SSR_OUTDIV_MSB      22
`define SSR_OUTDIV_LSB      20

// shadowed field masks
`define SSR_MOD_PHASE_SHADOW 32'h07FFFFF8
`define SSR_REF_CP_SHADOW    32'h03FFDE00
`define SSR_OUT_BAND_SHADOW  32'h00700000

// reset values and limits
`define SSR_WORD_RESET      32'h00000000
`define SSR_INT_MIN_P45     16'h0017
`define SSR_INT_MIN_P89     16'h004B

`endif

// File: logic/ssr_pin_sync.sv
`timescale 1ns/100ps
module ssr_pin_sync
  import ssr_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1 <= 1'h0;
          s2 <= 1'h0;
          s3 <= 1'h0;
          level[g] <= 1'h0;
        end
        else
        begin
          s1 <= pin_in[g];
          s2 <= s1;
          s3 <= s2;
          // accept a change only once two late stages agree
          if (s2 == s3)
            level[g] <= s3;
        end
      end
    end
  endgenerate

endmodule : ssr_pin_sync

// File: logic/ssr_pkg.sv
package ssr_pkg;

  typedef logic [31:0] ssr_word_t;

  // the six active configuration words as the analog side sees them
  typedef struct packed {
    ssr_word_t lock_pin_mode_word;
    ssr_word_t output_band_select_word;
    ssr_word_t clock_divider_mode_word;
    ssr_word_t reference_charge_pump_word;
    ssr_word_t modulus_phase_word;
    ssr_word_t integer_fraction_word;
  } ssr_cfg_s;

  // filtered serial pin levels
  typedef struct packed {
    logic serial_clock;
    logic serial_data;
    logic load_strobe;
  } ssr_pins_s;

endpackage : ssr_pkg

// File: logic/ssr_serial_bank.sv
// Summary of operation
// - A loaded word whose select bits are 000 is stored as the integer/fraction word.
// - The integer/fraction word carries a 16-bit whole-divide value in bits 30 down to 15.
// - The whole-divide value is presented as the integer part of the feedback division factor.
// - Shadowed fields wait in a stage after their own load and go active on the next integer/fraction load.
// - Output-divider select bits wait for an integer/fraction load only when bit 13 of the reference word is 1.
// - Serial data arrives MSB first and one bit enters the 32-bit shift register per serial clock rise.
// - A load strobe rise moves the shift register into the register chosen by bits 2 to 0.
// - Select codes 000 to 101 choose registers 0 to 5 in order.
`timescale 1ns/100ps
`include "ssr_map.svh"
module ssr_serial_bank
  import ssr_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  input  wire logic  serial_clock,
  input  wire logic  serial_data,
  input  wire logic  load_strobe,
  output ssr_cfg_s   cfg,
  output logic [15:0] whole_divide,
  output logic [11:0] numerator_value,
  output logic        int_numerator_value_loaded,
  output logic        divide_range_error
);

  function automatic logic sel_is(input logic [2:0] code, input logic [2:0] want);
    sel_is = (code == want);
  endfunction : sel_is

  ssr_pins_s   pins;
  logic [2:0]  pin_level;
  logic        sclk_q;
  logic        le_q;
  ssr_word_t   shift;
  ssr_word_t   stage_mod_phase;
  ssr_word_t   stage_ref_cp;
  ssr_word_t   stage_out_band;

  ssr_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin_in ({serial_clock, serial_data, load_strobe}),
    .level  (pin_level)
  );

  assign pins = pin_level;

  wire       sclk_rise = pins.serial_clock & ~sclk_q;
  wire       le_rise   = pins.load_strobe & ~le_q;
  wire [2:0] sel       = shift[2:0];
  wire       wr_r0     = le_rise & sel_is(sel, `SSR_SEL_INT_NUMERATOR_VALUE);
  wire       wr_r1     = le_rise & sel_is(sel, `SSR_SEL_MOD_PHASE);
  wire       wr_r2     = le_rise & sel_is(sel, `SSR_SEL_REF_CP);
  wire       wr_r3     = le_rise & sel_is(sel, `SSR_SEL_CLK_DIV);
  wire       wr_r4     = le_rise & sel_is(sel, `SSR_SEL_OUT_BAND);
  wire       wr_r5     = le_rise & sel_is(sel, `SSR_SEL_LOCK_PIN);
  wire [15:0] new_int  = shift[`SSR_INT_MSB:`SSR_INT_LSB];
  wire [31:0] out_mask = cfg.reference_charge_pump_word[`SSR_DBUF_EN_BIT] ?
                         `SSR_OUT_BAND_SHADOW : 32'h00000000;
  wire        p89      = cfg.modulus_phase_word[`SSR_PRESCALER_BIT];
  wire        int_bad  = p89 ? (new_int < `SSR_INT_MIN_P89) : (new_int < `SSR_INT_MIN_P45);

  // own write keeps shadowed bits, loads the rest at once
  wire [31:0] next_r1 = wr_r0 ? stage_mod_phase :
                        ((cfg.modulus_phase_word & `SSR_MOD_PHASE_SHADOW) |
                         (shift & ~`SSR_MOD_PHASE_SHADOW));
  wire [31:0] next_r2 = wr_r0 ? stage_ref_cp :
                        ((cfg.reference_charge_pump_word & `SSR_REF_CP_SHADOW) |
                         (shift & ~`SSR_REF_CP_SHADOW));
  wire [31:0] next_r4 = wr_r0 ? stage_out_band :
                        ((cfg.output_band_select_word & out_mask) | (shift & ~out_mask));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 1'h0;
      le_q   <= 1'h0;
      shift  <= `SSR_WORD_RESET;
    end
    else
    begin
      sclk_q <= pins.serial_clock;
      le_q   <= pins.load_strobe;
      if (sclk_rise)
        shift <= {shift[30:0], pins.serial_data};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_mod_phase <= `SSR_WORD_RESET;
      stage_ref_cp    <= `SSR_WORD_RESET;
      stage_out_band  <= `SSR_WORD_RESET;
    end
    else
    begin
      if (wr_r1)
        stage_mod_phase <= shift;
      if (wr_r2)
        stage_ref_cp <= shift;
      if (wr_r4)
        stage_out_band <= shift;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg                <= '0;
      whole_divide       <= 16'h0000;
      numerator_value    <= 12'h000;
      int_numerator_value_loaded    <= 1'h0;
      divide_range_error <= 1'h0;
    end
    else
    begin
      int_numerator_value_loaded <= wr_r0;
      if (wr_r0)
      begin
        cfg.integer_fraction_word <= shift;
        whole_divide              <= new_int;
        numerator_value           <= shift[`SSR_NUMERATOR_VALUE_MSB:`SSR_NUMERATOR_VALUE_LSB];
        divide_range_error        <= int_bad;
      end
      if (wr_r0 | wr_r1)
        cfg.modulus_phase_word <= next_r1;
      if (wr_r0 | wr_r2)
        cfg.reference_charge_pump_word <= next_r2;
      if (wr_r3)
        cfg.clock_divider_mode_word <= shift;
      if (wr_r0 | wr_r4)
        cfg.output_band_select_word <= next_r4;
      if (wr_r5)
        cfg.lock_pin_mode_word <= shift;
    end
  end

  property p_shift_in;
    @(posedge clock) disable iff (!rst_n)
    sclk_rise |=> shift == {$past(shift[30:0]), $past(pins.serial_data)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

  property p_int_load;
    @(posedge clock) disable iff (!rst_n)
    wr_r0 |=> whole_divide == $past(shift[30:15]) && cfg.integer_fraction_word == $past(shift);
  endproperty
  a_int_load: assert property (p_int_load) else $error("integer word not loaded");

  property p_int_mirror;
    @(posedge clock) disable iff (!rst_n)
    whole_divide == cfg.integer_fraction_word[30:15];
  endproperty
  a_int_mirror: assert property (p_int_mirror) else $error("divide value disagrees with word");

  property p_r1_hold;
    @(posedge clock) disable iff (!rst_n)
    wr_r1 |=> (cfg.modulus_phase_word & 32'h07FFFFF8) == $past(cfg.modulus_phase_word & 32'h07FFFFF8);
  endproperty
  a_r1_hold: assert property (p_r1_hold) else $error("shadowed field went active early");

  property p_r1_apply;
    @(posedge clock) disable iff (!rst_n)
    wr_r0 |=> cfg.modulus_phase_word == $past(stage_mod_phase);
  endproperty
  a_r1_apply: assert property (p_r1_apply) else $error("shadowed field not applied");

  property p_div_now;
    @(posedge clock) disable iff (!rst_n)
    wr_r4 && !cfg.reference_charge_pump_word[13] |=> cfg.output_band_select_word[22:20] == $past(shift[22:20]);
  endproperty
  a_div_now: assert property (p_div_now) else $error("divider select not immediate");

  property p_div_wait;
    @(posedge clock) disable iff (!rst_n)
    wr_r4 && cfg.reference_charge_pump_word[13] |=> $stable(cfg.output_band_select_word[22:20]);
  endproperty
  a_div_wait: assert property (p_div_wait) else $error("divider select not held");

  property p_direct_words;
    @(posedge clock) disable iff (!rst_n)
    wr_r3 |=> cfg.clock_divider_mode_word == $past(shift) && $stable(cfg.lock_pin_mode_word);
  endproperty
  a_direct_words: assert property (p_direct_words) else $error("register 3 routing wrong");

  property p_unmapped;
    @(posedge clock) disable iff (!rst_n)
    le_rise && sel > 3'h5 |=> $stable(cfg) && !int_numerator_value_loaded;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped code changed state");

  property p_load_pulse;
    @(posedge clock) disable iff (!rst_n)
    wr_r0 |=> int_numerator_value_loaded ##1 !int_numerator_value_loaded;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse wrong length");

  property p_range;
    @(posedge clock) disable iff (!rst_n)
    wr_r0 && !cfg.modulus_phase_word[27] && shift[30:15] < 16'h0017 |=> divide_range_error;
  endproperty
  a_range: assert property (p_range) else $error("low divide not flagged");

  property p_r2_hold;
    @(posedge clock) disable iff (!rst_n)
    wr_r2 |=> (cfg.reference_charge_pump_word & 32'h03FFDE00) ==
              $past(cfg.reference_charge_pump_word & 32'h03FFDE00);
  endproperty
  a_r2_hold: assert property (p_r2_hold) else $error("reference field went active early");

  property p_r24_apply;
    @(posedge clock) disable iff (!rst_n)
    wr_r0 |=> cfg.reference_charge_pump_word == $past(stage_ref_cp) &&
              cfg.output_band_select_word == $past(stage_out_band);
  endproperty
  a_r24_apply: assert property (p_r24_apply) else $error("staged words not applied");

  property p_range_both;
    @(posedge clock) disable iff (!rst_n)
    wr_r0 |=> divide_range_error ==
              ($past(shift[30:15]) < ($past(cfg.modulus_phase_word[27]) ? 16'h004B : 16'h0017));
  endproperty
  a_range_both: assert property (p_range_both) else $error("range flag wrong");

endmodule : ssr_serial_bank

// File: test/ssr_host.sv
`timescale 1ns/100ps
module ssr_host (
  input  wire logic clock,
  output logic      serial_clock,
  output logic      serial_data,
  output logic      load_strobe
);
  initial
  begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    load_strobe  = 1'b0;
  end

  // each level held 6 clocks, well past the pin filter
  task automatic send(input logic [31:0] word);
    for (int i = 31; i >= 0; i--)
    begin
      @(negedge clock);
      serial_clock = 1'b0;
      serial_data  = word[i];
      repeat (6) @(negedge clock);
      serial_clock = 1'b1;
      repeat (6) @(negedge clock);
    end
    serial_clock = 1'b0;
    repeat (6) @(negedge clock);
    load_strobe = 1'b1;
    repeat (6) @(negedge clock);
    load_strobe = 1'b0;
    // released data line shows no stale bit
    serial_data = ~word[0];
  endtask : send
endmodule : ssr_host

// File: test/testbench.sv
`timescale 1ns/100ps
`include "ssr_map.svh"
module testbench
  import ssr_pkg::*;
;
  logic        clock;
  logic        rst_n;
  logic        serial_clock;
  logic        serial_data;
  logic        load_strobe;
  ssr_cfg_s    cfg;
  logic [15:0] whole_divide;
  logic [11:0] numerator_value;
  logic        int_numerator_value_loaded;
  logic        divide_range_error;
  logic [31:0] d;
  logic        exp_range = 1'b0;
  int          fails = 0;
  int          check_count = 0;
  int          pulses = 0;
  int          exp_pulses = 0;
  int unsigned act [6] = '{default: 0};
  int unsigned stg [6] = '{default: 0};

  ssr_serial_bank uut (.clock(clock), .rst_n(rst_n), .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe), .cfg(cfg), .whole_divide(whole_divide), .numerator_value(numerator_value),
    .int_numerator_value_loaded(int_numerator_value_loaded), .divide_range_error(divide_range_error));
  ssr_host host (.clock(clock), .serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
    if (int_numerator_value_loaded === 1'b1)
      pulses <= pulses + 1;

  task results;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task check_all;
    for (int i = 0; i < 6; i++)
      cmp(cfg[32*i +: 32], act[i], "config word");
    cmp({16'h0000, whole_divide}, {16'h0000, act[0][30:15]}, "whole divide");
    cmp({20'h00000, numerator_value}, {20'h00000, act[0][14:3]}, "numerator");
    cmp({31'h0, divide_range_error}, {31'h0, exp_range}, "range flag");
    cmp(pulses, exp_pulses, "load pulses");
  endtask : check_all

  task automatic put(input logic [2:0] sel, input logic [31:0] data);
    logic [31:0] w;
    logic [31:0] m;
    // reserved positions written as zero
    m = sel == `SSR_SEL_MOD_PHASE ? 32'h1FFFFFFF : sel == `SSR_SEL_CLK_DIV ? 32'h00E5FFFF :
      sel == `SSR_SEL_OUT_BAND ? 32'h00FFFFFF : 32'h7FFFFFFF;
    w = {data[31:3], sel} & m;
    host.send(w);
    if (sel == `SSR_SEL_INT_NUMERATOR_VALUE)
    begin
      // flag judged against the prescaler active at this load
      exp_range = w[30:15] < (act[1][27] ? `SSR_INT_MIN_P89 : `SSR_INT_MIN_P45);
      act[0] = w;
      act[1] = stg[1];
      act[2] = stg[2];
      act[4] = stg[4];
      exp_pulses++;
    end
    else if (sel <= `SSR_SEL_LOCK_PIN)
    begin
      stg[sel] = w;
      m = sel == `SSR_SEL_MOD_PHASE ? `SSR_MOD_PHASE_SHADOW : sel == `SSR_SEL_REF_CP ? `SSR_REF_CP_SHADOW :
        (sel == `SSR_SEL_OUT_BAND && act[2][`SSR_DBUF_EN_BIT]) ? `SSR_OUT_BAND_SHADOW : 32'h00000000;
      act[sel] = (act[sel] & m) | (w & ~m);
    end
    repeat (10) @(negedge clock);
    check_all();
  endtask : put

  task automatic put0(input logic [15:0] n);
    put(`SSR_SEL_INT_NUMERATOR_VALUE, {1'b0, n, 15'($urandom)});
  endtask : put0

  initial
  begin
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    void'($urandom(32'hBC4D417A));
    repeat (2) @(negedge clock);
    check_all();
    for (int r = 0; r < 6; r++)
    begin
      d = $urandom;
      d[`SSR_DBUF_EN_BIT] = r[0];
      put(`SSR_SEL_REF_CP, d);
      put(`SSR_SEL_MOD_PHASE, $urandom);
      put(`SSR_SEL_OUT_BAND, $urandom);
      put(`SSR_SEL_CLK_DIV, $urandom);
      put(`SSR_SEL_LOCK_PIN, {8'h00, 2'($urandom), 3'b011, 19'h00000});
      put(`SSR_SEL_MOD_PHASE, $urandom);
      put({2'b11, r[0]}, $urandom);
      d = act[1][27] ? 75 : 23;
      put0(16'(d + $urandom % (65536 - d)));
    end
    put(`SSR_SEL_MOD_PHASE, 32'h00000008);
    put0(16'h0017);
    put0(16'hFFFF);
    put(`SSR_SEL_MOD_PHASE, 32'h08000008);
    put0(16'h004B);
    results();
  end

  initial
  begin
    #2400000;
    fails++;
    results();
  end
endmodule : testbench
